/* File: core/tcz_timer.v */
// general-purpose timer/counter with wishbone classic register access
// assumes pins are asynchronous to clk; sleepMode comes from clk domain
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "tcz_defines.vh"

module tcz_timer (
    input  wire                   clk,
    input  wire                   reset_n,
    input  wire                   wb_cyc_i,
    input  wire                   wb_stb_i,
    input  wire                   wb_we_i,
    input  wire [`TCZ_ADDR_W-1:0] wb_adr_i,
    input  wire [3:0]             wb_sel_i,
    input  wire [31:0]            wb_dat_i,
    output reg  [31:0]            wb_dat_o,
    output reg                    wb_ack_o,
    input  wire                   extClkPin,
    input  wire                   slowOscPin,
    input  wire                   auxOscPin,
    input  wire                   sleepMode,
    output reg                    matchPulseOut
);

// ==================================================================
// register state
reg [7:0] countLow_q;
reg [7:0] countHigh_q;
reg [7:0] trueHigh_q;
reg [7:0] period_q;
reg [7:0] controlA_q;
reg [7:0] controlB_q;
reg       overflow_q;
reg [3:0] post_q;
reg       pending_q;
reg [1:0] instrDiv_q;

wire       enable      = controlA_q[`TCZ_CA_ENABLE];
wire       widthSelect = controlA_q[`TCZ_CA_WIDTH];
wire [3:0] postSelect  = controlA_q[`TCZ_CA_POST_HI:`TCZ_CA_POST_LO];
wire [2:0] clockSource = controlB_q[`TCZ_CB_SRC_HI:`TCZ_CB_SRC_LO];
wire       asyncCount  = controlB_q[`TCZ_CB_ASYNC];
wire [3:0] prescaleSel = controlB_q[`TCZ_CB_PSC_HI:`TCZ_CB_PSC_LO];

// ==================================================================
// bus decode
function [2:0] regIndex;
    input [`TCZ_ADDR_W-1:0] adr;
    begin
        if (adr == `TCZ_OFS_COUNT_LOW) begin
            regIndex = 3'h1;
        end else if (adr == `TCZ_OFS_COUNT_HIGH) begin
            regIndex = 3'h2;
        end else if (adr == `TCZ_OFS_CONTROL_A) begin
            regIndex = 3'h3;
        end else if (adr == `TCZ_OFS_CONTROL_B) begin
            regIndex = 3'h4;
        end else if (adr == `TCZ_OFS_STATUS) begin
            regIndex = 3'h5;
        end else begin
            regIndex = 3'h0;
        end
    end
endfunction

wire       busReq    = wb_cyc_i && wb_stb_i;
// data is captured as ack rises; a write takes effect as the master sees ack
wire       readEdge  = busReq && !wb_ack_o && !wb_we_i;
wire       writeEdge = busReq && wb_ack_o && wb_we_i && wb_sel_i[0];
wire [2:0] rIdx      = regIndex(wb_adr_i);
wire [7:0] wByte     = wb_dat_i[7:0];

wire wrLow   = writeEdge && (rIdx == 3'h1);
wire wrHigh  = writeEdge && (rIdx == 3'h2);
wire wrCtlA  = writeEdge && (rIdx == 3'h3);
wire wrCtlB  = writeEdge && (rIdx == 3'h4);
wire wrStat  = writeEdge && (rIdx == 3'h5);
wire rdLow   = readEdge && (rIdx == 3'h1);
wire scClear = wrLow || wrCtlA || wrCtlB;

// ==================================================================
// clock sources
wire pinRise;
wire pinFall;
wire slowRise;
wire auxRise;

tcz_pin_sync uPinSync (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (extClkPin),
    .risePulse (pinRise),
    .fallPulse (pinFall)
);

tcz_pin_sync uSlowSync (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (slowOscPin),
    .risePulse (slowRise),
    .fallPulse ()
);

tcz_pin_sync uAuxSync (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (auxOscPin),
    .risePulse (auxRise),
    .fallPulse ()
);

// instruction cycle is one in four system clocks
wire instrTick = (instrDiv_q == `TCZ_INSTR_DIV);

// system-derived sources stop in sleep; oscillator and pin inputs run on
reg srcTick;
always @* begin
    case (clockSource)
        `TCZ_SRC_PIN_RISE: srcTick = pinRise;
        `TCZ_SRC_PIN_FALL: srcTick = pinFall;
        `TCZ_SRC_INSTR:    srcTick = instrTick && !sleepMode;
        `TCZ_SRC_SYSCLK:   srcTick = !sleepMode;
        `TCZ_SRC_SLOW_OSC: srcTick = slowRise;
        `TCZ_SRC_AUX_OSC:  srcTick = auxRise;
        default:           srcTick = 1'b0;
    endcase
end

wire pscTick;

tcz_prescaler uPrescaler (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (scClear),
    .select  (prescaleSel),
    .inTick  (srcTick && enable),
    .outTick (pscTick)
);

// sync mode waits for an instruction cycle and halts in sleep;
// ticks arriving faster than that collapse into one
wire syncTick = (pending_q || pscTick) && instrTick && !sleepMode;
wire cntTick  = asyncCount ? pscTick : syncTick;

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        instrDiv_q <= 2'h0;
        pending_q  <= 1'b0;
    end else begin
        instrDiv_q <= instrDiv_q + 2'h1;
        if (scClear || asyncCount || syncTick) begin
            pending_q <= 1'b0;
        end else if (pscTick) begin
            pending_q <= 1'b1;
        end
    end
end

// ==================================================================
// counting
wire        match8    = (countLow_q == period_q);
wire [15:0] count16   = {trueHigh_q, countLow_q};
wire        roll16    = (count16 == 16'hFFFF);
wire        eventTick = cntTick && (widthSelect ? roll16 : match8);
wire        postHit   = (post_q == postSelect);
wire        pulseSet  = eventTick && postHit;

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        countLow_q  <= `TCZ_RST_COUNT_LOW;
        countHigh_q <= `TCZ_RST_COUNT_HIGH;
        period_q    <= `TCZ_RST_COUNT_HIGH;
        trueHigh_q  <= `TCZ_RST_TRUE_HIGH;
    end else begin
        if (wrLow) begin
            countLow_q <= wByte;
            if (widthSelect) begin
                trueHigh_q <= countHigh_q;
            end
        end else if (cntTick && widthSelect) begin
            {trueHigh_q, countLow_q} <= count16 + 16'h0001;
        end else if (cntTick && match8) begin
            countLow_q <= 8'h00;
            period_q   <= countHigh_q;
        end else if (cntTick) begin
            countLow_q <= countLow_q + 8'h01;
        end
        // the readable high byte is a buffer in 16-bit mode, direct in 8-bit
        if (wrHigh) begin
            countHigh_q <= wByte;
        end else if (rdLow && widthSelect) begin
            countHigh_q <= trueHigh_q;
        end
    end
end

// ==================================================================
// postscaler, match pulse and overflow flag
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        post_q        <= 4'h0;
        matchPulseOut <= 1'b0;
        overflow_q    <= 1'b0;
    end else begin
        if (scClear) begin
            post_q <= 4'h0;
        end else if (eventTick) begin
            post_q <= postHit ? 4'h0 : post_q + 4'h1;
        end
        // the pulse lasts one prescaled counter period
        if (pulseSet) begin
            matchPulseOut <= 1'b1;
        end else if (cntTick || !enable) begin
            matchPulseOut <= 1'b0;
        end
        // a rollover in the clearing cycle wins over the clear
        if (eventTick && widthSelect) begin
            overflow_q <= 1'b1;
        end else if (wrStat && wByte[`TCZ_ST_OVERFLOW]) begin
            overflow_q <= 1'b0;
        end
    end
end

// ==================================================================
// control registers
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        controlA_q <= `TCZ_RST_CONTROL_A;
        controlB_q <= `TCZ_RST_CONTROL_B;
    end else begin
        if (wrCtlA) begin
            controlA_q <= wByte & `TCZ_CA_MASK;
        end
        if (wrCtlB) begin
            controlB_q <= wByte;
        end
    end
end

// ==================================================================
// bus answer: ack one cycle after the request, unmapped reads give zero
reg [7:0] readByte;
always @* begin
    case (rIdx)
        3'h1:    readByte = countLow_q;
        3'h2:    readByte = countHigh_q;
        3'h3:    readByte = controlA_q;
        3'h4:    readByte = controlB_q;
        3'h5:    readByte = {6'h00, overflow_q, matchPulseOut};
        default: readByte = 8'h00;
    endcase
end

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= busReq && !wb_ack_o;
        // read data stands only while ack is high, and is zero otherwise
        if (readEdge) begin
            wb_dat_o <= {24'h000000, readByte};
        end else if (wb_ack_o || !busReq) begin
            wb_dat_o <= 32'h00000000;
        end
    end
end

endmodule // tcz_timer

/* File: core/tcz_defines.vh */
// constants for the general-purpose timer/counter: offsets, fields, resets
// assumes a wishbone slave with 32-bit data, registers in the low byte
`ifndef TCZ_DEFINES_VH
`define TCZ_DEFINES_VH

// ==================================================================
// register byte offsets
`define TCZ_ADDR_W          5
`define TCZ_OFS_COUNT_LOW   5'h00
`define TCZ_OFS_COUNT_HIGH  5'h04
`define TCZ_OFS_CONTROL_A   5'h08
`define TCZ_OFS_CONTROL_B   5'h0C
`define TCZ_OFS_STATUS      5'h10

// ==================================================================
// timer_control_a fields
`define TCZ_CA_ENABLE       7
`define TCZ_CA_WIDTH        4
`define TCZ_CA_POST_HI      3
`define TCZ_CA_POST_LO      0
`define TCZ_CA_MASK         8'h9F

// timer_control_b fields
`define TCZ_CB_SRC_HI       7
`define TCZ_CB_SRC_LO       5
`define TCZ_CB_ASYNC        4
`define TCZ_CB_PSC_HI       3
`define TCZ_CB_PSC_LO       0

// status fields
`define TCZ_ST_MATCH        0
`define TCZ_ST_OVERFLOW     1

// ==================================================================
// clock source codes
`define TCZ_SRC_PIN_RISE    3'h0
`define TCZ_SRC_PIN_FALL    3'h1
`define TCZ_SRC_INSTR       3'h2
`define TCZ_SRC_SYSCLK      3'h3
`define TCZ_SRC_SLOW_OSC    3'h4
`define TCZ_SRC_AUX_OSC     3'h5

// ==================================================================
// reset values and sizes
`define TCZ_RST_COUNT_LOW   8'h00
`define TCZ_RST_COUNT_HIGH  8'hFF
`define TCZ_RST_TRUE_HIGH   8'h00
`define TCZ_RST_CONTROL_A   8'h00
`define TCZ_RST_CONTROL_B   8'h00
`define TCZ_PSC_W           15
`define TCZ_INSTR_DIV       2'h3

`endif

/* File: core/tcz_pin_sync.v */
// three-stage synchroniser with rise and fall pulses for one pin input
// assumes the pin is asynchronous to clk and slower than clk/4
`timescale 1ns/1ps

module tcz_pin_sync (
    input  wire clk,
    input  wire reset_n,
    input  wire pinIn,
    output reg  risePulse,
    output reg  fallPulse
);

// ==================================================================
// synchroniser and qualified edges
reg [2:0] stage_q;
reg       level_q;

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        stage_q   <= 3'h0;
        level_q   <= 1'b0;
        risePulse <= 1'b0;
        fallPulse <= 1'b0;
    end else begin
        stage_q   <= {stage_q[1:0], pinIn};
        risePulse <= 1'b0;
        fallPulse <= 1'b0;
        // only stages two and three vote; stage one feeds stage two alone
        if (stage_q[1] == stage_q[2] && stage_q[2] != level_q) begin
            level_q   <= stage_q[2];
            risePulse <= stage_q[2];
            fallPulse <= ~stage_q[2];
        end
    end
end

endmodule // tcz_pin_sync

/* File: core/tcz_prescaler.v */
// 15-bit prescaler: passes one tick out of 2**select incoming ticks
// assumes inTick is a one-cycle enable on clk
`timescale 1ns/1ps
`include "tcz_defines.vh"

module tcz_prescaler (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       clear,
    input  wire [3:0] select,
    input  wire       inTick,
    output wire       outTick
);

// ==================================================================
// ratio mask
function [`TCZ_PSC_W-1:0] ratioMask;
    input [3:0] sel;
    begin
        ratioMask = ~({`TCZ_PSC_W{1'b1}} << sel);
    end
endfunction

reg  [`TCZ_PSC_W-1:0] count_q;
wire [`TCZ_PSC_W-1:0] mask = ratioMask(select);

// select zero bypasses the divider: every input tick passes
assign outTick = inTick && ((count_q & mask) == mask);

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        count_q <= {`TCZ_PSC_W{1'b0}};
    end else if (clear) begin
        count_q <= {`TCZ_PSC_W{1'b0}};
    end else if (inTick) begin
        count_q <= count_q + 1'b1;
    end
end

endmodule // tcz_prescaler

/* File: tb/tcz_timer_asserts.sv */
// bus and pulse checks for the timer/counter, bound to tcz_timer ports
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`include "tcz_defines.vh"

module tcz_timer_asserts (
    input wire                   clk,
    input wire                   reset_n,
    input wire                   wb_cyc_i,
    input wire                   wb_stb_i,
    input wire                   wb_we_i,
    input wire [`TCZ_ADDR_W-1:0] wb_adr_i,
    input wire [31:0]            wb_dat_o,
    input wire                   wb_ack_o,
    input wire                   matchPulseOut
);
    // ==================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire rdReq = req & ~wb_we_i;
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_single; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_upper; wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("upper data set");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data while idle");
    property p_unmapped; rdReq && wb_adr_i > `TCZ_OFS_STATUS |=> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_ctla; rdReq && wb_adr_i == `TCZ_OFS_CONTROL_A |=> wb_dat_o[6:5] == 2'h0; endproperty
    a_ctla: assert property (p_ctla) else $error("reserved bits set");
    property p_pulse_reset; $rose(reset_n) |-> !matchPulseOut; endproperty
    a_pulse_reset: assert property (p_pulse_reset) else $error("pulse after reset");
endmodule // tcz_timer_asserts

bind tcz_timer tcz_timer_asserts tcz_timer_asserts_i (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .matchPulseOut(matchPulseOut));

/* File: tb/tcz_clk_src.sv */
// far side: external count pin and two oscillators
// assumes the bench calls burst() from its own process
`timescale 1ns/1ps

module tcz_clk_src (
    input  wire  oscEn,
    output logic extClkPin,
    output logic slowOscPin,
    output logic auxOscPin
);
    initial begin
        extClkPin = 1'b0;
        slowOscPin = 1'b0;
        auxOscPin = 1'b0;
    end
    // 40 ns per edge, 80 ns per pin cycle, keeps the pin below the instruction rate for sync mode
    task burst(input int n);
        repeat (n) begin
            #40 extClkPin = 1'b1;
            #40 extClkPin = 1'b0;
        end
    endtask
    // oscillators stand low while disabled
    always begin
        #50 slowOscPin = oscEn ? ~slowOscPin : 1'b0;
    end
    always begin
        #30 auxOscPin = oscEn ? ~auxOscPin : 1'b0;
    end
endmodule // tcz_clk_src

/* File: tb/tcz_timer_tb_top.sv */
// self-checking bench for the timer/counter over wishbone classic
// assumes tcz_clk_src drives the pins
`timescale 1ns/1ps
`include "tcz_defines.vh"

module tcz_timer_tb_top;
    logic                   clk, reset_n, cyc, stb, we, sleepMode, oscEn, pq;
    logic [`TCZ_ADDR_W-1:0] adr;
    logic [31:0]            datI;
    logic [7:0]             r, a0;
    wire  [31:0]            datO;
    wire                    ack, extPin, slowPin, auxPin, pulse;
    int                     nErrors, checksDone, pulseCnt;

    tcz_timer tcz_timer_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_ack_o(ack), .extClkPin(extPin), .slowOscPin(slowPin), .auxOscPin(auxPin),
        .sleepMode(sleepMode), .matchPulseOut(pulse));
    tcz_clk_src tcz_clk_src_i (.oscEn(oscEn), .extClkPin(extPin), .slowOscPin(slowPin),
        .auxOscPin(auxPin));

    // ==================================================================
    // tasks
    task finishTest;
        $display("errors %0d checks %0d", nErrors, checksDone);
        if (nErrors == 0 && checksDone > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = datO[7:0];
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50) begin
            nErrors++;
            finishTest;
        end
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d); wb(1'b1, a, d); endtask
    task rd(input logic [4:0] a); wb(1'b0, a, 8'h00); endtask
    // pin edges reach the counter through a 3-4 cycle synchroniser
    task edges(input int n); tcz_clk_src_i.burst(n); repeat (8) @(posedge clk); endtask

    always @(posedge clk) begin
        if (pulse === 1'b1 && pq !== 1'b1) pulseCnt++;
        pq <= pulse;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==================================================================
    // tests
    initial begin
        {reset_n, cyc, stb, we, sleepMode, oscEn, adr, datI} = '0;
        {nErrors, checksDone, pulseCnt} = '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h00);
        rd(`TCZ_OFS_COUNT_HIGH); check(r, 8'hFF);
        rd(`TCZ_OFS_CONTROL_A); check(r, 8'h00);
        rd(`TCZ_OFS_CONTROL_B); check(r, 8'h00);
        rd(5'h14); check(r, 8'h00);
        $display("test reset done");
        wr(`TCZ_OFS_CONTROL_B, 8'h10); wr(`TCZ_OFS_CONTROL_A, 8'h10);
        wr(`TCZ_OFS_COUNT_HIGH, 8'h12); wr(`TCZ_OFS_COUNT_LOW, 8'hFE);
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'hFE);
        rd(`TCZ_OFS_COUNT_HIGH); check(r, 8'h12);
        wr(`TCZ_OFS_CONTROL_A, 8'h90); edges(3);
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h01);
        rd(`TCZ_OFS_COUNT_HIGH); check(r, 8'h13);
        wr(`TCZ_OFS_COUNT_HIGH, 8'hFF); wr(`TCZ_OFS_COUNT_LOW, 8'hFF); edges(1);
        rd(`TCZ_OFS_STATUS); check(r & 8'h02, 8'h02);
        check({7'h0, pulse}, 8'h01);
        wr(`TCZ_OFS_STATUS, 8'h02);
        $display("test 16-bit done");
        for (int p = 0; p < 4; p++) begin
            wr(`TCZ_OFS_CONTROL_B, 8'h10 | p[7:0]); wr(`TCZ_OFS_COUNT_LOW, 8'h00);
            edges(8);
            rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h08 >> p);
        end
        wr(`TCZ_OFS_CONTROL_B, 8'h12); wr(`TCZ_OFS_COUNT_LOW, 8'h00); edges(3);
        wr(`TCZ_OFS_CONTROL_B, 8'h12); edges(3);
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h00);
        $display("test prescaler done");
        sleepMode <= 1'b1;
        wr(`TCZ_OFS_CONTROL_B, 8'h00); wr(`TCZ_OFS_COUNT_LOW, 8'h00); edges(4);
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h00);
        wr(`TCZ_OFS_CONTROL_B, 8'h10); wr(`TCZ_OFS_COUNT_LOW, 8'h00); edges(4);
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h04);
        sleepMode <= 1'b0;
        wr(`TCZ_OFS_CONTROL_B, 8'h00); wr(`TCZ_OFS_COUNT_LOW, 8'h00); edges(4);
        rd(`TCZ_OFS_COUNT_LOW); check(r, 8'h04);
        $display("test sync done");
        for (int s = 2; s < 4; s++) begin
            wr(`TCZ_OFS_CONTROL_B, {s[2:0], 5'h10});
            rd(`TCZ_OFS_COUNT_LOW); a0 = r;
            repeat (37) @(posedge clk);
            rd(`TCZ_OFS_COUNT_LOW); check(r - a0, s == 2 ? 8'd10 : 8'd40);
        end
        oscEn = 1'b1;
        for (int s = 4; s < 6; s++) begin
            wr(`TCZ_OFS_CONTROL_B, {s[2:0], 5'h10}); wr(`TCZ_OFS_COUNT_LOW, 8'h00);
            repeat (200) @(posedge clk);
            rd(`TCZ_OFS_COUNT_LOW);
            a0 = s == 4 ? 8'd9 : 8'd15;
            check({7'h0, r >= a0 && r <= a0 + 8'd3}, 8'h01);
        end
        oscEn = 1'b0;
        $display("test sources done");
        wr(`TCZ_OFS_CONTROL_B, 8'h10); wr(`TCZ_OFS_CONTROL_A, 8'h80);
        wr(`TCZ_OFS_COUNT_HIGH, 8'h03);
        rd(`TCZ_OFS_COUNT_HIGH); check(r, 8'h03);
        wr(`TCZ_OFS_COUNT_LOW, 8'hFE); edges(2);
        wr(`TCZ_OFS_COUNT_LOW, 8'h00); pulseCnt = 0; edges(8);
        check(pulseCnt[7:0], 8'h02);
        $display("test 8-bit done");
        finishTest;
    end
endmodule // tcz_timer_tb_top
